// [ccc_core.sv]
`timescale 1ns/1ps
// Operation
// - Halt opcode stops program instruction fetch
// - Twenty-one usable coordinates (indices 0-20) kept per axis
// - Index zero volatile, others also nonvolatile
// - Set-coordinate stores signed value by type
// - Direct-mode success replies status 100
// - Program get-coordinate loads accumulator
// - Direct get-coordinate returns value, keeps accumulator
// - Capture copies actual position into slot
// - Coordinates are 24 bits wide
// - X calc writes result to accumulator, X register, or both (swap)
// - Types 0-7 arithmetic and logic ops
// - Types 8-10 invert, load, swap
module ccc_core
    import ccc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // Direct-mode byte stream from host
    input  wire logic        byte_valid_in,
    input  wire logic [7:0]  byte_in,
    // Stand-alone program instruction
    input  wire logic        run_in,
    input  wire logic        prog_valid_in,
    input  wire logic [71:0] prog_word_in,
    output logic             prog_fetch_out,
    output logic             prog_halted_out,
    // Axis position
    input  wire logic [23:0] actual_pos_in,
    // Coordinate read port for moves
    input  wire logic [4:0]  move_index_in,
    output logic [23:0]      move_target_out,
    // Nonvolatile write request
    output logic             nv_write_out,
    output logic [4:0]       nv_index_out,
    output logic [23:0]      nv_data_out,
    // Reply frame
    output logic             reply_valid_out,
    output logic [71:0]      reply_out,
    // State
    output logic [31:0]      acc_out,
    output logic [31:0]      x_out
);
    logic        frame_valid;
    logic [71:0] frame;
    logic        sum_ok;
    logic [23:0] coord [COORD_N];
    logic [31:0] acc;
    logic [31:0] xreg;
    logic [31:0] next_acc;
    logic [31:0] next_x;
    logic        halted;

    // Command source: direct frame wins over program word
    logic        direct;
    logic        exec;
    logic [7:0]  opcode;
    logic [7:0]  ctype;
    logic [31:0] value;
    logic        idx_ok;
    logic [4:0]  idx;

    ccc_frame_rx u_rx (
        .clk_in          (clk_in),
        .rst_n_in        (rst_n_in),
        .byte_valid_in   (byte_valid_in),
        .byte_in         (byte_in),
        .frame_valid_out (frame_valid),
        .frame_out       (frame),
        .sum_ok_out      (sum_ok)
    );

    ccc_alu u_alu (
        .op_in   (ctype[3:0]),
        .acc_in  (acc),
        .x_in    (xreg),
        .acc_out (next_acc),
        .x_out   (next_x)
    );

    // Decode the active command
    always_comb begin
        direct = frame_valid;
        exec   = frame_valid ? sum_ok : (prog_valid_in && run_in && !halted);
        opcode = frame_valid ? frame[63:56] : prog_word_in[63:56];
        ctype  = frame_valid ? frame[55:48] : prog_word_in[55:48];
        value  = frame_valid ? frame[39:8]  : prog_word_in[39:8];
        idx_ok = (ctype <= COORD_MAX);
        idx    = ctype[4:0];
    end

    // Program fetch runs until halt
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            halted <= 1'b0;
        end else if (!run_in) begin
            halted <= 1'b0;
        end else if (exec && !direct && opcode == OP_HALT) begin
            halted <= 1'b1;
        end
    end
    assign prog_fetch_out  = run_in && !halted;
    assign prog_halted_out = halted;

    // Coordinate array storage
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < COORD_N; i++) begin
                coord[i] <= 24'h000000;
            end
        end else if (exec && idx_ok) begin
            if (opcode == OP_SET_CO) begin
                coord[idx] <= value[23:0];
            end else if (opcode == OP_CAP_CO) begin
                coord[idx] <= actual_pos_in;
            end
        end
    end
    assign move_target_out = (move_index_in <= COORD_MAX[4:0]) ? coord[move_index_in] : 24'h0;

    // Nonvolatile copy for every index but zero
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            nv_write_out <= 1'b0;
            nv_index_out <= 5'h00;
            nv_data_out  <= 24'h000000;
        end else begin
            nv_write_out <= exec && idx_ok && idx != COORD_VOL
                            && (opcode == OP_SET_CO || opcode == OP_CAP_CO);
            nv_index_out <= idx;
            nv_data_out  <= (opcode == OP_SET_CO) ? value[23:0] : actual_pos_in;
        end
    end

    // Accumulator and X register
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            acc  <= ACC_RST;
            xreg <= XREG_RST;
        end else if (exec) begin
            if (opcode == OP_GET_CO && idx_ok && !direct) begin
                acc <= {{8{coord[idx][23]}}, coord[idx]};
            end else if (opcode == OP_CALC_WITH_X_REGISTER && ctype <= 8'(CCC_SWAP)) begin
                acc  <= next_acc;
                xreg <= next_x;
            end
        end
    end
    assign acc_out = acc;
    assign x_out   = xreg;

    // Reply frame in direct mode
    logic [7:0]  r_status;
    logic [31:0] r_value;
    logic [63:0] r_body;
    always_comb begin
        r_value  = 32'h0;
        r_status = ST_OK;
        if (!sum_ok) begin
            r_status = ST_BAD_SUM;
        end else if ((opcode == OP_SET_CO || opcode == OP_GET_CO
                      || opcode == OP_CAP_CO) && !idx_ok) begin
            r_status = ST_BAD_VAL;
        end else if (opcode == OP_GET_CO) begin
            r_value = {{8{coord[idx][23]}}, coord[idx]};
        end
        r_body = {REPLY_ADDR, DEV_ADDR, r_status, opcode, r_value};
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reply_valid_out <= 1'b0;
            reply_out       <= 72'h0;
        end else begin
            reply_valid_out <= direct;
            if (direct) begin
                reply_out <= {r_body, ccc_sum8({r_body, 8'h00})};
            end
        end
    end

    // Halt blocks fetch from the next cycle on
    a_halt_stops_fetch: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (exec && !direct && opcode == OP_HALT && run_in) |=> !prog_fetch_out)
        else $error("fetch continued after halt");
    // Halt flag holds while stand-alone mode stays on
    a_halt_holds: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (halted && run_in) |=> halted)
        else $error("halt flag dropped while running");
    // Set stores value into selected slot
    a_set_stores: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (exec && opcode == OP_SET_CO && idx_ok) |=> coord[$past(idx)] == $past(value[23:0]))
        else $error("set coordinate not stored");
    // Capture stores actual position
    a_capture_pos: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (exec && opcode == OP_CAP_CO && idx_ok) |=> coord[$past(idx)] == $past(actual_pos_in))
        else $error("capture not stored");
    // Slot zero never goes to nonvolatile store
    a_slot0_volatile: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        nv_write_out |-> nv_index_out != COORD_VOL)
        else $error("slot zero written to nonvolatile");
    // Nonvolatile write follows a set of a nonzero slot
    a_nv_follows_set: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (exec && opcode == OP_SET_CO && idx_ok && idx != COORD_VOL) |=> nv_write_out)
        else $error("nonvolatile write missing");
    // Nonvolatile write follows a capture of a nonzero slot
    a_capture_nv: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (exec && opcode == OP_CAP_CO && idx_ok && idx != COORD_VOL)
        |=> nv_write_out && nv_data_out == $past(actual_pos_in))
        else $error("capture not sent to nonvolatile");
    // Out-of-range index never reaches the nonvolatile store
    a_bad_index_nv: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (exec && !idx_ok) |=> !nv_write_out)
        else $error("bad index written to nonvolatile");
    // Direct get leaves accumulator unchanged
    a_direct_get_acc: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (direct && opcode == OP_GET_CO) |=> $stable(acc))
        else $error("direct get changed accumulator");
    // Program get loads accumulator
    a_prog_get_acc: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (exec && !direct && opcode == OP_GET_CO && idx_ok)
        |=> acc[23:0] == $past(coord[idx]))
        else $error("program get missed accumulator");
    // Direct get returns the stored coordinate, sign-extended
    a_direct_get_value: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (direct && sum_ok && opcode == OP_GET_CO && idx_ok)
        |=> reply_out[31:8] == $past(coord[idx]) && reply_out[39:32] == {8{reply_out[31]}})
        else $error("direct get value wrong");
    // Swap exchanges both registers
    a_calc_swap: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (exec && opcode == OP_CALC_WITH_X_REGISTER && ctype == 8'(CCC_SWAP))
        |=> acc == $past(xreg) && xreg == $past(acc))
        else $error("swap failed");
    // Add writes sum into accumulator
    a_calc_add: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (exec && opcode == OP_CALC_WITH_X_REGISTER && ctype == 8'(CCC_ADD))
        |=> acc == $past(acc) + $past(xreg))
        else $error("add result wrong");
    // Subtract takes X register from accumulator
    a_calc_sub: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (exec && opcode == OP_CALC_WITH_X_REGISTER && ctype == 8'(CCC_SUB))
        |=> acc == $past(acc) - $past(xreg))
        else $error("subtract result wrong");
    // Multiply keeps the low 32 bits of the signed product
    a_calc_mul: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (exec && opcode == OP_CALC_WITH_X_REGISTER && ctype == 8'(CCC_MUL))
        |=> acc == 32'($signed($past(acc)) * $signed($past(xreg))))
        else $error("multiply result wrong");
    // Signed divide by a nonzero X register
    a_calc_div: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (exec && opcode == OP_CALC_WITH_X_REGISTER && ctype == 8'(CCC_DIV) && xreg != 32'h0)
        |=> acc == 32'($signed($past(acc)) / $signed($past(xreg))))
        else $error("divide result wrong");
    // Exclusive or into accumulator
    a_calc_xor: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (exec && opcode == OP_CALC_WITH_X_REGISTER && ctype == 8'(CCC_XOR))
        |=> acc == ($past(acc) ^ $past(xreg)))
        else $error("xor result wrong");
    // Invert touches only the X register
    a_calc_not: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (exec && opcode == OP_CALC_WITH_X_REGISTER && ctype == 8'(CCC_NOT))
        |=> xreg == ~$past(xreg) && acc == $past(acc))
        else $error("invert result wrong");
    // Load copies accumulator into X register
    a_calc_load: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (exec && opcode == OP_CALC_WITH_X_REGISTER && ctype == 8'(CCC_LOAD))
        |=> xreg == $past(acc) && acc == $past(acc))
        else $error("load result wrong");
    // Unknown calculation type changes nothing
    a_calc_bad_type: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (exec && opcode == OP_CALC_WITH_X_REGISTER && ctype > 8'(CCC_SWAP))
        |=> acc == $past(acc) && xreg == $past(xreg))
        else $error("unknown calculation changed state");
    // Good direct capture frame replies with status 100 one cycle later
    a_reply_ok: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (direct && sum_ok && opcode == OP_CAP_CO && idx_ok)
        |=> reply_valid_out && reply_out[55:48] == ST_OK)
        else $error("reply status not ok");
    // Reply carries fixed address bytes
    a_reply_addr: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        reply_valid_out |-> reply_out[71:56] == {REPLY_ADDR, DEV_ADDR})
        else $error("reply address wrong");
    // Reply checksum is the 8-bit sum of its first eight bytes
    a_reply_sum: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        reply_valid_out |-> reply_out[7:0] == 8'(reply_out[71:64] + reply_out[63:56]
            + reply_out[55:48] + reply_out[47:40] + reply_out[39:32] + reply_out[31:24]
            + reply_out[23:16] + reply_out[15:8]))
        else $error("reply checksum wrong");
    // Reply strobe lasts a single cycle
    a_reply_pulse: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        reply_valid_out |=> !reply_valid_out)
        else $error("reply strobe too long");
    // Bad checksum answers with its own status
    a_bad_sum_reply: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (direct && !sum_ok)
        |=> reply_valid_out && reply_out[55:48] == ST_BAD_SUM)
        else $error("bad checksum status missing");
    // Bad checksum executes nothing
    a_bad_sum_inert: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (direct && !sum_ok)
        |=> !nv_write_out && acc == $past(acc) && xreg == $past(xreg))
        else $error("bad checksum frame executed");
endmodule

// [ccc_pkg.sv]
package ccc_pkg;
    // Instruction opcodes
    localparam logic [7:0] OP_HALT    = 8'h1C;
    localparam logic [7:0] OP_SET_CO  = 8'h1E;
    localparam logic [7:0] OP_GET_CO  = 8'h1F;
    localparam logic [7:0] OP_CAP_CO  = 8'h20;
    localparam logic [7:0] OP_CALC_WITH_X_REGISTER   = 8'h21;
    // Coordinate store geometry and frame length
    localparam int         COORD_W    = 24;
    localparam int         COORD_N    = 21;
    localparam logic [7:0] COORD_MAX  = 8'h14;
    localparam logic [4:0] COORD_VOL  = 5'h00;
    localparam int         FRAME_LEN  = 9;
    // Reply status codes
    localparam logic [7:0] ST_OK      = 8'h64;
    localparam logic [7:0] ST_BAD_SUM = 8'h01;
    localparam logic [7:0] ST_BAD_VAL = 8'h04;
    // Reply address defaults
    localparam logic [7:0] REPLY_ADDR = 8'h02;
    localparam logic [7:0] DEV_ADDR   = 8'h01;
    // Reset values
    localparam logic [31:0] ACC_RST   = 32'h0000_0000;
    localparam logic [31:0] XREG_RST  = 32'h0000_0000;
    // Calculation selectors
    typedef enum logic [3:0] {
        CCC_ADD, CCC_SUB, CCC_MUL, CCC_DIV, CCC_REM, CCC_AND,
        CCC_OR, CCC_XOR, CCC_NOT, CCC_LOAD, CCC_SWAP
    } ccc_calc_e;

    // Eight-bit sum of the first eight frame bytes
    function automatic logic [7:0] ccc_sum8(input logic [71:0] f);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 1; i < FRAME_LEN; i++) begin
            s = s + f[i*8 +: 8];
        end
        return s;
    endfunction
endpackage

// [ccc_frame_rx.sv]
`timescale 1ns/1ps
// Collects nine bytes into a frame and checks its sum
module ccc_frame_rx
    import ccc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // Byte stream
    input  wire logic        byte_valid_in,
    input  wire logic [7:0]  byte_in,
    // Frame out
    output logic             frame_valid_out,
    output logic [71:0]      frame_out,
    output logic             sum_ok_out
);
    logic [3:0]  count;
    logic [71:0] shreg;

    // Shift bytes in, first byte lands at the top
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count <= 4'h0;
            shreg <= 72'h0;
            frame_valid_out <= 1'b0;
        end else begin
            frame_valid_out <= 1'b0;
            if (byte_valid_in) begin
                shreg <= {shreg[63:0], byte_in};
                if (count == 4'(FRAME_LEN - 1)) begin
                    count <= 4'h0;
                    frame_valid_out <= 1'b1;
                end else begin
                    count <= count + 4'h1;
                end
            end
        end
    end

    // Last byte is checksum of the rest
    assign frame_out  = shreg;
    assign sum_ok_out = (ccc_sum8(shreg) == shreg[7:0]);
endmodule

// [ccc_alu.sv]
`timescale 1ns/1ps
// Accumulator and X register arithmetic
module ccc_alu
    import ccc_pkg::*;
(
    // Operands
    input  wire logic [3:0]  op_in,
    input  wire logic [31:0] acc_in,
    input  wire logic [31:0] x_in,
    // Results
    output logic [31:0]      acc_out,
    output logic [31:0]      x_out
);
    // Divide by zero leaves accumulator unchanged
    always_comb begin
        acc_out = acc_in;
        x_out   = x_in;
        unique case (op_in)
            4'(CCC_ADD): acc_out = acc_in + x_in;
            4'(CCC_SUB): acc_out = acc_in - x_in;
            4'(CCC_MUL): acc_out = 32'($signed(acc_in) * $signed(x_in));
            4'(CCC_DIV): if (x_in != 32'h0) acc_out = 32'($signed(acc_in) / $signed(x_in));
            4'(CCC_REM): if (x_in != 32'h0) acc_out = 32'($signed(acc_in) % $signed(x_in));
            4'(CCC_AND): acc_out = acc_in & x_in;
            4'(CCC_OR):  acc_out = acc_in | x_in;
            4'(CCC_XOR): acc_out = acc_in ^ x_in;
            4'(CCC_NOT): x_out = ~x_in;
            4'(CCC_LOAD): x_out = acc_in;
            4'(CCC_SWAP): begin
                x_out   = acc_in;
                acc_out = x_in;
            end
            default: ;
        endcase
    end
endmodule

// [ccc_host_model.sv]
`timescale 1ns/1ps
// Host side: builds and sends nine-byte command frames
module ccc_host_model
    import ccc_pkg::*;
(
    // Clock
    input  wire logic  clk_in,
    // Byte stream to device
    output logic       byte_valid_out,
    output logic [7:0] byte_out
);
    // Frame builder, bank field always zero
    function automatic logic [71:0] mk(input logic [7:0] op, input logic [7:0] typ,
                                       input logic [31:0] val);
        logic [63:0] h;
        logic [7:0]  s;
        h = {DEV_ADDR, op, typ, 8'h00, val};
        s = 8'h00;
        for (int i = 0; i < 8; i++) begin
            s = s + h[i*8 +: 8];
        end
        return {h, s};
    endfunction
    // Idle at time zero
    initial begin
        byte_valid_out = 1'b0;
        byte_out       = 8'h00;
    end
    // Bytes back to back, first byte first; idle line shows inverse of last byte
    task automatic send(input logic [71:0] f);
        for (int i = 8; i >= 0; i--) begin
            @(posedge clk_in);
            #1;
            byte_valid_out = 1'b1;
            byte_out       = f[i*8 +: 8];
        end
        @(posedge clk_in);
        #1;
        byte_valid_out = 1'b0;
        byte_out       = ~byte_out;
    endtask
endmodule

// [coordinate_and_calc_commands_tb.sv]
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin err_count++; \
    $display("wrong value %s exp %h got %h", nm, exp, got); end end
module coordinate_and_calc_commands_tb;
    import ccc_pkg::*;
    logic        clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        run_in = 1'b0;
    logic        prog_valid_in = 1'b0;
    logic [71:0] prog_word_in = 72'h0;
    logic [23:0] actual_pos_in = 24'h0;
    logic [4:0]  move_index_in = 5'h0;
    logic        byte_valid;
    logic [7:0]  byte_val;
    logic        prog_fetch_out, prog_halted_out, nv_write_out, reply_valid_out;
    logic [4:0]  nv_index_out;
    logic [23:0] move_target_out, nv_data_out;
    logic [71:0] reply_out;
    logic [31:0] acc_out, x_out;
    int          err_count = 0;
    int          n_tests = 0;
    logic [71:0] corrupt = 72'h0;
    logic [31:0] ea [11] = '{107, 93, 700, 14, 2, 4, 103, 99, 100, 100, 7};
    logic [31:0] ex [11] = '{7, 7, 7, 7, 7, 7, 7, 7, 32'hFFFF_FFF8, 100, 100};
    // Clock
    always #2 clk_in = ~clk_in;
    ccc_host_model h (.clk_in(clk_in), .byte_valid_out(byte_valid), .byte_out(byte_val));
    ccc_core uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .byte_valid_in(byte_valid),
        .byte_in(byte_val), .run_in(run_in), .prog_valid_in(prog_valid_in),
        .prog_word_in(prog_word_in), .prog_fetch_out(prog_fetch_out),
        .prog_halted_out(prog_halted_out), .actual_pos_in(actual_pos_in),
        .move_index_in(move_index_in), .move_target_out(move_target_out),
        .nv_write_out(nv_write_out), .nv_index_out(nv_index_out), .nv_data_out(nv_data_out),
        .reply_valid_out(reply_valid_out), .reply_out(reply_out), .acc_out(acc_out),
        .x_out(x_out));
    // Verdict and end of run
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Direct command, then bounded wait for the reply pulse
    task automatic cmd(input logic [7:0] op, input logic [7:0] typ, input logic [31:0] val);
        int k;
        k = 0;
        h.send(h.mk(op, typ, val) ^ corrupt);
        while (reply_valid_out !== 1'b1 && k < 20) begin
            @(posedge clk_in);
            #1;
            k++;
        end
        if (k >= 20) begin
            err_count++;
            $display("wrong value reply_valid exp 1 got 0");
            conclude();
        end
    endtask
    // One program word from stand-alone memory
    task automatic prog(input logic [7:0] op, input logic [7:0] typ);
        @(posedge clk_in);
        #1;
        prog_valid_in = 1'b1;
        prog_word_in  = h.mk(op, typ, 32'h0);
        @(posedge clk_in);
        #1;
        prog_valid_in = 1'b0;
        repeat (3) @(posedge clk_in);
        #1;
    endtask
    // Store nonzero and zero index, read back through move port
    task automatic t_set();
        cmd(OP_SET_CO, 8'h01, 32'hFF80_0001);
        `CHK("status", ST_OK, reply_out[55:48])
        `CHK("nv_write", 1'b1, nv_write_out)
        `CHK("nv_index", 5'h01, nv_index_out)
        `CHK("nv_data", 24'h80_0001, nv_data_out)
        move_index_in = 5'h01;
        #1;
        `CHK("target", 24'h80_0001, move_target_out)
        cmd(OP_SET_CO, 8'h00, 32'h0000_0123);
        `CHK("nv_write0", 1'b0, nv_write_out)
        move_index_in = 5'h00;
        #1;
        `CHK("target0", 24'h00_0123, move_target_out)
        cmd(OP_SET_CO, 8'h15, 32'h0000_0055);
        `CHK("bad_status", ST_BAD_VAL, reply_out[55:48])
        `CHK("bad_nv", 1'b0, nv_write_out)
        $display("set done");
    endtask
    // Direct read returns value, accumulator untouched
    task automatic t_get();
        cmd(OP_GET_CO, 8'h01, 32'h0);
        `CHK("get_value", 32'hFF80_0001, reply_out[39:8])
        `CHK("get_op", OP_GET_CO, reply_out[47:40])
        `CHK("get_acc", ACC_RST, acc_out)
        `CHK("get_reply", 72'h02_01_64_1F_FF_80_00_01_06, reply_out)
        $display("get done");
    endtask
    // Corrupt checksum: refused, nothing stored
    task automatic t_bad();
        corrupt = 72'h01;
        cmd(OP_SET_CO, 8'h01, 32'h0000_0777);
        corrupt = 72'h0;
        `CHK("sum_status", ST_BAD_SUM, reply_out[55:48])
        `CHK("sum_nv", 1'b0, nv_write_out)
        move_index_in = 5'h01;
        #1;
        `CHK("sum_target", 24'h80_0001, move_target_out)
        $display("checksum done");
    endtask
    // Capture position into the last slot
    task automatic t_cap();
        actual_pos_in = 24'h5A_A5C3;
        cmd(OP_CAP_CO, 8'h14, 32'h0);
        `CHK("cap_status", ST_OK, reply_out[55:48])
        `CHK("cap_nv", 5'h14, nv_index_out)
        `CHK("cap_nvdata", 24'h5A_A5C3, nv_data_out)
        actual_pos_in = 24'h00_0000;
        move_index_in = 5'h14;
        #1;
        `CHK("cap_target", 24'h5A_A5C3, move_target_out)
        $display("capture done");
    endtask
    // Every X-register operation on acc 100 and x 7
    task automatic t_calc();
        cmd(OP_SET_CO, 8'h02, 32'd100);
        cmd(OP_SET_CO, 8'h03, 32'd7);
        run_in = 1'b1;
        for (int t = 0; t < 11; t++) begin
            prog(OP_GET_CO, 8'h03);
            `CHK("prog_get", 32'd7, acc_out)
            cmd(OP_CALC_WITH_X_REGISTER, 8'h09, 32'h0);
            prog(OP_GET_CO, 8'h02);
            cmd(OP_CALC_WITH_X_REGISTER, t[7:0], 32'h0);
            `CHK("calc_acc", ea[t], acc_out)
            `CHK("calc_x", ex[t], x_out)
        end
        cmd(OP_CALC_WITH_X_REGISTER, 8'h0B, 32'h0);
        `CHK("calc_bad_st", ST_OK, reply_out[55:48])
        `CHK("calc_bad_acc", 32'd7, acc_out)
        `CHK("calc_bad_x", 32'd100, x_out)
        $display("calc done");
    endtask
    // Halt word ends fetching; run low clears it
    task automatic t_halt();
        `CHK("fetch_on", 1'b1, prog_fetch_out)
        prog(OP_HALT, 8'h00);
        `CHK("halted", 1'b1, prog_halted_out)
        `CHK("fetch_off", 1'b0, prog_fetch_out)
        prog(OP_GET_CO, 8'h02);
        `CHK("halt_acc", 32'd7, acc_out)
        run_in = 1'b0;
        @(posedge clk_in);
        #1;
        `CHK("unhalt", 1'b0, prog_halted_out)
        $display("halt done");
    endtask
    // Mid-run reset with halt flag set; first command byte sampled at the second edge after release
    task automatic t_reset();
        run_in = 1'b1;
        prog(OP_HALT, 8'h00);
        `CHK("rst_pre", 1'b1, prog_halted_out)
        rst_n_in = 1'b0;
        @(posedge clk_in);
        #1;
        `CHK("rst_acc", ACC_RST, acc_out)
        `CHK("rst_x", XREG_RST, x_out)
        `CHK("rst_halt", 1'b0, prog_halted_out)
        `CHK("rst_fetch", 1'b1, prog_fetch_out)
        `CHK("rst_target", 24'h00_0000, move_target_out)
        rst_n_in = 1'b1;
        cmd(OP_GET_CO, 8'h14, 32'h0);
        `CHK("rst_get", 32'h0, reply_out[39:8])
        `CHK("rst_acc2", ACC_RST, acc_out)
        $display("reset done");
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge clk_in);
        #1;
        rst_n_in = 1'b1;
        t_set();
        t_get();
        t_bad();
        t_cap();
        t_calc();
        t_halt();
        t_reset();
        conclude();
    end
endmodule
